// ===== core/tcc_pkg.sv
// constants, types and register map of the timer capture/compare channels
// Contract
// - seven prescaler rates chosen by prescaler_select
// - active pin edge copies counter into value
// - capture happens whatever the event flag holds
// - captured value lands three cycles after edge
// - capture sets event flag, enabled flag requests irq
// - next capture overwrites the earlier value
// - reset leaves channel value registers untouched
// - compare match sets, clears or toggles pin
// - compare match flags event and may request irq
// - unbuffered value write replaces compare value directly
// - buffered_link_select links channels onto channel 0 pin
// - linked pair starts on channel 0 value
// - last written value takes control at overflow
// - linked: chan0 control reports, chan1 pin released
// - counter reaching modulo sets overflow flag, enabled flag requests irq
// - buffered_link_select outranks single_mode_select
package tcc_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_MODULO = 5'h04;
	localparam logic [4:0] OFS_COUNT = 5'h08;
	localparam logic [4:0] OFS_CH0_CTRL = 5'h0C;
	localparam logic [4:0] OFS_CH0_VALUE = 5'h10;
	localparam logic [4:0] OFS_CH1_CTRL = 5'h14;
	localparam logic [4:0] OFS_CH1_VALUE = 5'h18;
	// status register fields
	localparam int unsigned ST_PS_LSB = 0;
	localparam int unsigned ST_OVF_IE = 3;
	localparam int unsigned ST_OVF_FLAG = 4;
	localparam int unsigned ST_STOP = 5;
	// channel control fields beyond the packed control bits
	localparam int unsigned CH_FLAG = 5;
	localparam int unsigned CH_ACTIVE = 6;
	// widths and reset values
	localparam int unsigned CNT_W = 16;
	localparam int unsigned DIV_W = 6;
	localparam logic [2:0] PS_MAX = 3'h6;
	localparam logic [15:0] MODULO_RST = 16'hFFFF;
	localparam logic [2:0] PS_RST = 3'h0;
	// edge / action encodings on {hi, lo}
	localparam logic [1:0] ELS_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;

	// channel control bits as they sit in the register
	typedef struct packed {
		logic channel_irq_enable;
		logic buffered_link_select;
		logic single_mode_select;
		logic edge_level_select_hi;
		logic edge_level_select_lo;
	} tcc_ctrl_t;

	// pin synchroniser state
	typedef struct packed {
		logic meta;
		logic lvl;
		logic prev;
	} tcc_sync_t;

	// resettable state of the channel block
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [2:0] prescaler_select;
		logic overflow_irq_enable;
		logic overflow_flag;
		logic stop;
		logic [15:0] modulo;
		logic [15:0] count;
		logic [5:0] div;
		tcc_ctrl_t [1:0] ctrl;
		logic [1:0] channel_event_flags;
		logic active_sel;
		logic last_written;
		logic [1:0] pin_o;
		logic [1:0] pin_oe;
		logic [1:0] irq_chan;
		logic irq_overflow;
	} tcc_state_t;

	// channel value pair, no reset
	typedef struct packed {
		logic [1:0][15:0] channel_value_pair;
	} tcc_value_t;
endpackage

// ===== core/tcc_pin_sync.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module tcc_pin_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// raw pin level
	input wire logic pin_i,
	// edge pulses, one cycle each
	output logic rise,
	output logic fall
);
	tcc_pkg::tcc_sync_t s_q; // current state
	tcc_pkg::tcc_sync_t s_d; // next state

	// shift the pin through; only lvl and prev are looked at
	always_comb
	begin
		s_d = s_q;
		s_d.meta = pin_i;
		s_d.lvl = s_q.meta;
		s_d.prev = s_q.lvl;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// edges from two successive synchronised samples
	assign rise = s_q.lvl & ~s_q.prev;
	assign fall = ~s_q.lvl & s_q.prev;
endmodule

// ===== core/tcc_channels.sv
// two-channel capture/compare timer with apb register access
`timescale 1ns/1ps
module tcc_channels (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [4:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel pins
	input wire logic chan0_pin_i,
	output logic chan0_pin_o,
	output logic chan0_pin_oe,
	input wire logic chan1_pin_i,
	output logic chan1_pin_o,
	output logic chan1_pin_oe,
	// interrupt requests
	output logic [1:0] irq_chan,
	output logic irq_overflow
);
	tcc_pkg::tcc_state_t s_q; // resettable state
	tcc_pkg::tcc_state_t s_d; // its next value
	tcc_pkg::tcc_value_t v_q; // value registers, no reset
	tcc_pkg::tcc_value_t v_d; // their next value
	logic [1:0] rise; // rising edge seen on each pin
	logic [1:0] fall; // falling edge seen on each pin

	// synchronisers for both pins
	tcc_pin_sync u_sync0 (
		.pclk(pclk),
		.presetn(presetn),
		.pin_i(chan0_pin_i),
		.rise(rise[0]),
		.fall(fall[0])
	);
	tcc_pin_sync u_sync1 (
		.pclk(pclk),
		.presetn(presetn),
		.pin_i(chan1_pin_i),
		.rise(rise[1]),
		.fall(fall[1])
	);

	// working signals of the next-state logic
	logic acc; // first access cycle of an apb transfer
	logic wr; // write completes this edge
	logic [2:0] ps_eff; // prescaler select clipped to seven rates
	logic [5:0] mask; // low divider bits that must be all ones
	logic tick; // counter advances this cycle
	logic ovf; // counter wraps this tick
	logic [15:0] cnt_nx; // counter value after this cycle
	logic linked; // channels joined into a buffered pair
	logic [1:0] comp; // channel in compare mode
	logic [1:0] cap; // channel in capture mode
	logic [1:0] hit; // capture edge qualifies
	logic [1:0] match; // compare match this tick
	logic [1:0][15:0] cv; // compare value in force per channel
	logic [1:0] els; // edge / action bits of a channel
	logic mapped; // address hits a register

	// next-state logic for bus, prescaler, counter and channels
	always_comb
	begin
		s_d = s_q;
		v_d = v_q;
		acc = psel & penable & ~s_q.pready;
		wr = psel & penable & pwrite & s_q.pready;
		// prescaler: divide by 1,2,4..64
		ps_eff = (s_q.prescaler_select > tcc_pkg::PS_MAX) ? tcc_pkg::PS_MAX
			: s_q.prescaler_select;
		mask = 6'((7'h01 << ps_eff) - 7'h01);
		tick = ~s_q.stop & ((s_q.div & mask) == mask);
		s_d.div = s_q.div + 6'h01;
		// counter wraps after reaching modulo
		ovf = tick & (s_q.count == s_q.modulo);
		cnt_nx = s_q.count;
		if (ovf)
		begin
			cnt_nx = '0;
		end
		else if (tick)
		begin
			cnt_nx = s_q.count + 16'h0001;
		end
		s_d.count = cnt_nx;
		// mode decode; link outranks single mode on channel 0
		linked = s_q.ctrl[0].buffered_link_select;
		comp[0] = linked | s_q.ctrl[0].single_mode_select;
		comp[1] = ~linked & s_q.ctrl[1].single_mode_select;
		cap[0] = ~comp[0];
		cap[1] = ~linked & ~comp[1];
		// buffered pair uses whichever value is active
		cv[0] = (linked & s_q.active_sel) ? v_q.channel_value_pair[1]
			: v_q.channel_value_pair[0];
		cv[1] = v_q.channel_value_pair[1];
		// bus read: register mux sampled in first access cycle
		s_d.pready = acc;
		mapped = 1'b1;
		if (acc)
		begin
			s_d.prdata = '0;
			case (paddr)
				tcc_pkg::OFS_STATUS:
				begin
					s_d.prdata[tcc_pkg::ST_PS_LSB +: 3] = s_q.prescaler_select;
					s_d.prdata[tcc_pkg::ST_OVF_IE] = s_q.overflow_irq_enable;
					s_d.prdata[tcc_pkg::ST_OVF_FLAG] = s_q.overflow_flag;
					s_d.prdata[tcc_pkg::ST_STOP] = s_q.stop;
				end
				tcc_pkg::OFS_MODULO: s_d.prdata[15:0] = s_q.modulo;
				tcc_pkg::OFS_COUNT: s_d.prdata[15:0] = s_q.count;
				tcc_pkg::OFS_CH0_CTRL:
				begin
					// channel 0 control also reports the buffered pair
					s_d.prdata[4:0] = s_q.ctrl[0];
					s_d.prdata[tcc_pkg::CH_FLAG] = s_q.channel_event_flags[0];
					s_d.prdata[tcc_pkg::CH_ACTIVE] = s_q.active_sel;
				end
				tcc_pkg::OFS_CH0_VALUE: s_d.prdata[15:0] = v_q.channel_value_pair[0];
				tcc_pkg::OFS_CH1_CTRL:
				begin
					s_d.prdata[4:0] = s_q.ctrl[1];
					s_d.prdata[tcc_pkg::CH_FLAG] = s_q.channel_event_flags[1];
				end
				tcc_pkg::OFS_CH1_VALUE: s_d.prdata[15:0] = v_q.channel_value_pair[1];
				default: mapped = 1'b0;
			endcase
			s_d.pslverr = ~mapped;
		end
		else
		begin
			// refusal stands only with its single-cycle answer
			s_d.pslverr = 1'b0;
		end
		// bus write: takes effect at the completing edge
		if (wr)
		begin
			case (paddr)
				tcc_pkg::OFS_STATUS:
				begin
					s_d.prescaler_select = pwdata[tcc_pkg::ST_PS_LSB +: 3];
					s_d.overflow_irq_enable = pwdata[tcc_pkg::ST_OVF_IE];
					s_d.stop = pwdata[tcc_pkg::ST_STOP];
					// write one clears the overflow flag
					if (pwdata[tcc_pkg::ST_OVF_FLAG])
					begin
						s_d.overflow_flag = 1'b0;
					end
				end
				tcc_pkg::OFS_MODULO: s_d.modulo = pwdata[15:0];
				tcc_pkg::OFS_CH0_CTRL:
				begin
					s_d.ctrl[0] = tcc_pkg::tcc_ctrl_t'(pwdata[4:0]);
					// fresh link starts on channel 0 value
					if (pwdata[3] & ~linked)
					begin
						s_d.active_sel = 1'b0;
						s_d.last_written = 1'b0;
					end
					if (pwdata[tcc_pkg::CH_FLAG])
					begin
						s_d.channel_event_flags[0] = 1'b0;
					end
				end
				tcc_pkg::OFS_CH1_CTRL:
				begin
					// channel 1 control is unused while linked
					if (!linked)
					begin
						s_d.ctrl[1] = tcc_pkg::tcc_ctrl_t'(pwdata[4:0]);
					end
					if (pwdata[tcc_pkg::CH_FLAG])
					begin
						s_d.channel_event_flags[1] = 1'b0;
					end
				end
				tcc_pkg::OFS_CH0_VALUE:
				begin
					// direct replacement, no holding register
					v_d.channel_value_pair[0] = pwdata[15:0];
					s_d.last_written = 1'b0;
				end
				tcc_pkg::OFS_CH1_VALUE:
				begin
					v_d.channel_value_pair[1] = pwdata[15:0];
					s_d.last_written = 1'b1;
				end
				default:
				begin
					s_d.modulo = s_q.modulo;
				end
			endcase
		end
		// overflow: flag set wins over a clear in the same cycle
		if (ovf)
		begin
			s_d.overflow_flag = 1'b1;
			if (linked)
			begin
				s_d.active_sel = s_d.last_written;
			end
		end
		s_d.irq_overflow = s_d.overflow_flag & s_d.overflow_irq_enable;
		// per-channel capture and compare
		for (int ch = 0; ch < 2; ch++)
		begin
			els = {s_q.ctrl[ch].edge_level_select_hi, s_q.ctrl[ch].edge_level_select_lo};
			hit[ch] = cap[ch] & ((els[0] & rise[ch]) | (els[1] & fall[ch]));
			match[ch] = comp[ch] & tick & (cnt_nx == cv[ch]);
			// capture regardless of flag; later capture overwrites
			if (hit[ch])
			begin
				v_d.channel_value_pair[ch] = s_q.count;
			end
			// events set the flag after any software clear
			if (hit[ch] | match[ch])
			begin
				s_d.channel_event_flags[ch] = 1'b1;
			end
			// pin action on compare match
			if (match[ch])
			begin
				case (els)
					tcc_pkg::ACT_TOGGLE: s_d.pin_o[ch] = ~s_q.pin_o[ch];
					tcc_pkg::ACT_CLEAR: s_d.pin_o[ch] = 1'b0;
					tcc_pkg::ACT_SET: s_d.pin_o[ch] = 1'b1;
					default: s_d.pin_o[ch] = s_q.pin_o[ch];
				endcase
			end
			// drive the pin only in compare mode with an action chosen
			s_d.pin_oe[ch] = comp[ch] & (els != tcc_pkg::ELS_OFF);
			s_d.irq_chan[ch] = s_d.channel_event_flags[ch]
				& s_d.ctrl[ch].channel_irq_enable;
		end
		// linked pair drives channel 0 pin only
		if (linked)
		begin
			s_d.pin_oe[1] = 1'b0;
		end
	end

	// resettable state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.modulo <= tcc_pkg::MODULO_RST;
			s_q.prescaler_select <= tcc_pkg::PS_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// value registers keep their contents through reset
	always_ff @(posedge pclk)
	begin
		v_q <= v_d;
	end

	// outputs straight from flip-flops
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign chan0_pin_o = s_q.pin_o[0];
	assign chan0_pin_oe = s_q.pin_oe[0];
	assign chan1_pin_o = s_q.pin_o[1];
	assign chan1_pin_oe = s_q.pin_oe[1];
	assign irq_chan = s_q.irq_chan;
	assign irq_overflow = s_q.irq_overflow;
endmodule

// ===== tb/tcc_channels_monitor.sv
// port checker for the timer channel block
`timescale 1ns/1ps
module tcc_channels_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [4:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// interrupt requests
	input wire logic [1:0] irq_chan,
	input wire logic irq_overflow
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// answer lasts a single cycle
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	// answer only inside an access
	a_ready_cause: assert property (pready |-> psel && penable) else $error("stray pready");
	// one wait state: never answered in the first access cycle
	a_setup_wait: assert property (psel && !penable |=> !pready) else $error("no wait state");
	// waiting access is answered on the next edge
	a_access_done: assert property (psel && penable && !pready |=> pready)
		else $error("late pready");
	// unmapped place is refused
	a_err_unmapped: assert property (psel && penable && !pready && paddr > 5'h18 |=> pslverr)
		else $error("no pslverr");
	// refusal only with the answer of a bad place
	a_err_only: assert property (pslverr |-> pready && (paddr > 5'h18 || paddr[1:0] != 2'h0))
		else $error("stray pslverr");
	// read data moves only with an answer
	a_read_hold: assert property ($changed(prdata) |-> pready) else $error("prdata moved");
	// refused read returns zero
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	// counter is sixteen bits wide
	a_count_width: assert property (pready && !pwrite && paddr == tcc_pkg::OFS_COUNT |->
		prdata[31:16] == 16'h0) else $error("counter too wide");
	// main scenarios reached
	cover property (pready && pwrite);
	cover property (pready && pslverr);
	cover property ($rose(irq_chan[0]));
	cover property ($rose(irq_overflow));
endmodule
bind tcc_channels tcc_channels_monitor u_tcc_channels_monitor (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq_chan(irq_chan), .irq_overflow(irq_overflow));

// ===== tb/tcc_pin_model.sv
// outside signals on the two channel pins
`timescale 1ns/1ps
module tcc_pin_model (
	// levels the outside world applies
	input wire logic [1:0] ext,
	// block drive and enable
	input wire logic [1:0] o,
	input wire logic [1:0] oe,
	// resolved pin levels
	output logic [1:0] pin
);
	// block wins where it drives, else the outside level, changing at any time
	assign pin = {oe[1] ? o[1] : ext[1], oe[0] ? o[0] : ext[0]};
endmodule

// ===== tb/tcc_channels_bench.sv
// self-checking bench for the timer channel block
`timescale 1ns/1ps
module tcc_channels_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [4:0] paddr = 5'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] ext = 2'h0;
	logic [1:0] po;
	logic [1:0] poe;
	logic [1:0] pin;
	logic [1:0] irq_chan;
	logic irq_overflow;
	logic [31:0] rd;
	logic err;
	logic [15:0] cnt;
	logic [31:0] cap;
	logic [1:0] acts [3] = '{tcc_pkg::ACT_SET, tcc_pkg::ACT_CLEAR, tcc_pkg::ACT_TOGGLE};
	int n_errors = 0;
	int compares = 0;
	// 125 MHz bus clock
	always #4 pclk = ~pclk;
	tcc_channels u_tcc_channels (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chan0_pin_i(pin[0]), .chan0_pin_o(po[0]),
		.chan0_pin_oe(poe[0]), .chan1_pin_i(pin[1]), .chan1_pin_o(po[1]),
		.chan1_pin_oe(poe[1]), .irq_chan(irq_chan), .irq_overflow(irq_overflow));
	tcc_pin_model u_tcc_pin_model (.ext(ext), .o(po), .oe(poe), .pin(pin));
	// one apb transfer, held until pready is sampled
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		// a transfer that is never answered counts as a mismatch
		if (pready !== 1'b1)
		begin
			n_errors++;
			$display("ERROR pready exp 1 got %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	// bounded wait on the overflow request or the channel 0 pin
	task automatic wait_for(input logic s, input logic e);
		int k;
		k = 0;
		while ((s ? irq_overflow : pin[0]) !== e && k < 300)
		begin
			@(posedge pclk);
			k++;
		end
	endtask
	// verdict and end of run
	task automatic close_out;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard
	initial
	begin
		repeat (40000) @(posedge pclk);
		n_errors++;
		close_out;
	end
	// test sequence
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, tcc_pkg::OFS_MODULO, 32'h0);
		chk("modulo", 32'hFFFF, rd);
		xfer(0, 5'h1C, 32'h0);
		chk("slverr", 1'b1, err);
		$display("test reset done");
		for (int p = 0; p < 8; p++)
		begin
			xfer(1, tcc_pkg::OFS_STATUS, p);
			xfer(0, tcc_pkg::OFS_COUNT, 32'h0);
			cnt = rd[15:0];
			repeat (252) @(posedge pclk);
			xfer(0, tcc_pkg::OFS_COUNT, 32'h0);
			chk("rate", 16'h0100 >> ((p > 6) ? 6 : p), 16'(rd[15:0] - cnt));
		end
		$display("test prescaler done");
		xfer(1, tcc_pkg::OFS_STATUS, 32'h20);
		xfer(0, tcc_pkg::OFS_COUNT, 32'h0);
		cnt = rd[15:0];
		xfer(1, tcc_pkg::OFS_CH0_CTRL, 32'h11);
		for (int i = 0; i < 2; i++)
		begin
			ext[0] <= 1'b1;
			repeat (4) @(posedge pclk);
			xfer(0, tcc_pkg::OFS_CH0_VALUE, 32'h0);
			cap = rd;
			chk("capture", {16'h0, cnt}, rd);
			chk("irq_chan", 1'b1, irq_chan[0]);
			xfer(1, tcc_pkg::OFS_STATUS, 32'h00);
			xfer(1, tcc_pkg::OFS_STATUS, 32'h20);
			xfer(0, tcc_pkg::OFS_COUNT, 32'h0);
			cnt = rd[15:0];
			ext[0] <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, tcc_pkg::OFS_CH0_VALUE, 32'h0);
		chk("kept", cap, rd);
		$display("test capture done");
		xfer(1, tcc_pkg::OFS_MODULO, 32'h40);
		xfer(1, tcc_pkg::OFS_CH0_VALUE, 32'h10);
		for (int i = 0; i < 3; i++)
		begin
			xfer(1, tcc_pkg::OFS_CH0_CTRL, {27'h0, 3'h1, acts[i]});
			wait_for(0, i != 1);
			chk("pin", i != 1, pin[0]);
			chk("oe", 1'b1, poe[0]);
		end
		xfer(0, tcc_pkg::OFS_CH0_CTRL, 32'h0);
		chk("flag", 1'b1, rd[5]);
		xfer(1, tcc_pkg::OFS_STATUS, 32'h18);
		wait_for(1, 1);
		chk("irq_ovf", 1'b1, irq_overflow);
		// raise the value right after an overflow, as software should
		xfer(1, tcc_pkg::OFS_CH0_VALUE, 32'h30);
		xfer(1, tcc_pkg::OFS_CH0_CTRL, 32'h25);
		repeat (70) @(posedge pclk);
		xfer(0, tcc_pkg::OFS_CH0_CTRL, 32'h0);
		chk("flag_hi", 1'b1, rd[5]);
		// lower the value while the count is already above it
		xfer(1, tcc_pkg::OFS_CH0_VALUE, 32'h08);
		xfer(1, tcc_pkg::OFS_CH0_CTRL, 32'h25);
		repeat (70) @(posedge pclk);
		xfer(0, tcc_pkg::OFS_CH0_CTRL, 32'h0);
		chk("flag_lo", 1'b1, rd[5]);
		$display("test compare done");
		xfer(1, tcc_pkg::OFS_CH0_CTRL, 32'h0F);
		xfer(0, tcc_pkg::OFS_CH0_CTRL, 32'h0);
		chk("active", 1'b0, rd[6]);
		chk("oe1", 1'b0, poe[1]);
		xfer(1, tcc_pkg::OFS_CH1_VALUE, 32'h20);
		xfer(1, tcc_pkg::OFS_STATUS, 32'h18);
		wait_for(1, 0);
		wait_for(1, 1);
		xfer(0, tcc_pkg::OFS_CH0_CTRL, 32'h0);
		chk("active", 1'b1, rd[6]);
		$display("test buffered done");
		close_out;
	end
endmodule
